// [design/flash_cmd_pkg.sv]
// constants, encodings and carrier types for the flash bank command interpreter
package flash_cmd_pkg;

   // address geometry: byte address on the bus, 16-bit word address inside
   localparam int AXI_AW    = 18;
   localparam int WA_W      = AXI_AW - 2;
   localparam int BANK_W    = 2;
   localparam int NBANK     = 1 << BANK_W;
   localparam int BLK_W     = 4;
   localparam int NBLK      = 1 << BLK_W;
   localparam int BUF_WORDS = 32;
   localparam int CNT_W     = 5;
   localparam int TIMER_W   = 16;
   localparam logic [CNT_W-1:0] BUF_LAST = 5'h1f;

   // command codes
   localparam logic [7:0] OPC_READ_ARRAY  = 8'hff;
   localparam logic [7:0] OPC_READ_STATUS = 8'h70;
   localparam logic [7:0] OPC_READ_SIG    = 8'h90;
   localparam logic [7:0] OPC_QUERY       = 8'h98;
   localparam logic [7:0] OPC_CLEAR_STAT  = 8'h50;
   localparam logic [7:0] OPC_ERASE_SETUP = 8'h20;
   localparam logic [7:0] OPC_PROG_SETUP  = 8'h40;
   localparam logic [7:0] OPC_PROG_ALT    = 8'h10;
   localparam logic [7:0] OPC_BUF_PROG    = 8'he8;
   localparam logic [7:0] OPC_FACTORY     = 8'h80;
   localparam logic [7:0] OPC_CONFIRM     = 8'hd0;
   localparam logic [7:0] OPC_SUSPEND     = 8'hb0;

   // status byte bit positions
   localparam int SR_READY_BIT    = 7;
   localparam int SR_ERASE_ERR    = 5;
   localparam int SR_PROG_ERR     = 4;
   localparam int SR_PROT_ERR     = 1;

   localparam logic [1:0] RESP_OKAY = 2'h0;

   typedef enum logic [1:0] {MODE_ARRAY, MODE_STATUS, MODE_SIG, MODE_QUERY} read_mode_e;

   typedef enum logic [2:0] {
      CS_IDLE, CS_ERASE_SETUP, CS_PROG_SETUP, CS_BUF_COUNT,
      CS_BUF_LOAD, CS_BUF_CONFIRM, CS_FACT_SETUP, CS_FACT_LOAD
   } cmd_state_e;

   typedef enum logic [1:0] {OP_NONE, OP_WORD, OP_ERASE, OP_BUF} pe_op_e;

   // request to the array: one-cycle program or erase strobes with address and data
   typedef struct packed {
      logic             wr;
      logic             erase;
      logic [WA_W-1:0]  addr;
      logic [15:0]      data;
   } pe_req_s;

   // program/erase controller
   typedef struct packed {
      logic               busy;
      pe_op_e             op;
      logic [TIMER_W-1:0] timer;
      logic [CNT_W-1:0]   idx;
      logic [CNT_W-1:0]   last;
      logic [WA_W-1:0]    pa;
      logic [15:0]        pd;
   } pe_ctl_s;

   // whole state of the interpreter
   typedef struct packed {
      logic                            aw_have;
      logic [WA_W-1:0]                 aw_wa;
      logic                            w_have;
      logic [15:0]                     w_data;
      logic                            awready;
      logic                            wready;
      logic                            bvalid;
      logic                            arready;
      logic                            rd_pend;
      logic                            rvalid;
      logic [31:0]                     rdata;
      logic [WA_W-1:0]                 raddr;
      read_mode_e [NBANK-1:0]          mode;
      cmd_state_e                      cs;
      logic [WA_W-1:0]                 base;
      logic [WA_W-1:0]                 start;
      logic [CNT_W-1:0]                nwords;
      logic [CNT_W:0]                  loaded;
      logic [BUF_WORDS-1:0][15:0]      wbuf;
      logic                            ers_err;
      logic                            prg_err;
      logic                            prot_err;
      pe_ctl_s                         ctl;
      pe_req_s                         pe;
   } state_s;

endpackage

// [design/flash_cmd_interp.sv]
// command interpreter for a multi-bank nor flash, flash space mapped onto axi4-lite
//
// How it works
// - query write puts addressed bank in query
// - query accepted even while programming or erasing
// - query changes only addressed bank's mode
// - clear-status zeroes error flags, mode kept
// - error flags sticky, but misaligned factory confirm in unlocked block clears prot_err; host clears before commands
// - erase sets block ones; protected block errors
// - erase needs setup plus confirm; else errors
// - erase start puts bank in status mode
// - busy bank takes only read modes; suspend ignored
// - reset pin aborts erase; host re-erases
// - word program setup then address/data write
// - programming bank reads return status
// - reset pin aborts program; host erases first
// - buffer setup shows status, ready means free
// - second buffer write carries count n
// - n+1 loads within start to start+n
// - confirm starts; bad sequence errors, no change
// - buffer setup refused with both errors set
// - factory buffer refills while inside one block
// - factory needs unlocked aligned constant start
// - confirm code meaning follows preceding setup
// - undefined write sequences are ignored
// - array read after reset and supply lockout
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module flash_cmd_interp
   import flash_cmd_pkg::*;
#(
   parameter int unsigned WORD_PROG_CYCLES = 200,
   parameter int unsigned ERASE_CYCLES     = 4000,
   parameter logic [15:0] SIG_CODE         = 16'h5a5a  // arbitrary signature value
)(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [AXI_AW-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [AXI_AW-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic              reset_pin_low,
   input  wire logic              vdd_low,
   input  wire logic [NBLK-1:0]   block_protect,
   input  wire logic [15:0]       array_rdata,
   input  wire logic [15:0]       cfi_rdata,
   output logic [WA_W-1:0]        array_raddr,
   output pe_req_s                pe_req,
   output logic                   pe_busy
);

   localparam logic [TIMER_W-1:0] WORD_T  = TIMER_W'(WORD_PROG_CYCLES - 1);
   localparam logic [TIMER_W-1:0] ERASE_T = TIMER_W'(ERASE_CYCLES - 1);

   state_s s_q;
   state_s s_d;

   logic [7:0]        cmd;
   logic [WA_W-1:0]   wa;
   logic [BANK_W-1:0] wbank;
   logic [BLK_W-1:0]  wblk;
   logic [BLK_W-1:0]  base_blk;
   logic [BLK_W-1:0]  start_blk;
   logic [BANK_W-1:0] busy_bank;
   logic              busy_here;
   logic              do_write;
   logic [7:0]        status;
   logic [WA_W-1:0]   eff_start;
   logic [WA_W-1:0]   offset;

   assign cmd       = s_q.w_data[7:0];
   assign wa        = s_q.aw_wa;
   assign wbank     = wa[WA_W-1 -: BANK_W];
   assign wblk      = wa[WA_W-1 -: BLK_W];
   assign base_blk  = s_q.base[WA_W-1 -: BLK_W];
   assign start_blk = s_q.start[WA_W-1 -: BLK_W];
   assign busy_bank = s_q.ctl.pa[WA_W-1 -: BANK_W];
   assign busy_here = s_q.ctl.busy && (busy_bank == wbank);
   assign do_write  = s_q.aw_have && s_q.w_have && !s_q.bvalid;
   // first load word fixes the start address
   assign eff_start = (s_q.loaded == '0) ? wa : s_q.start;
   assign offset    = wa - eff_start;

   always_comb begin
      status = 8'h00;
      status[SR_READY_BIT] = !s_q.ctl.busy;
      status[SR_ERASE_ERR] = s_q.ers_err;
      status[SR_PROG_ERR]  = s_q.prg_err;
      status[SR_PROT_ERR]  = s_q.prot_err;
   end

   always_comb begin
      s_d = s_q;
      s_d.pe.wr    = 1'b0;
      s_d.pe.erase = 1'b0;

      // ---------------- axi write channels
      if (awvalid && s_q.awready) begin
         s_d.aw_have = 1'b1;
         s_d.aw_wa   = awaddr[AXI_AW-1:2];
      end
      if (wvalid && s_q.wready) begin
         s_d.w_have = 1'b1;
         s_d.w_data = wdata[15:0];
      end
      if (s_q.bvalid && bready) begin
         s_d.bvalid = 1'b0;
      end

      // ---------------- program/erase controller
      if (s_q.ctl.busy) begin
         if (s_q.ctl.timer != '0) begin
            s_d.ctl.timer = s_q.ctl.timer - 1'b1;
         end else begin
            case (s_q.ctl.op)
               OP_ERASE: begin
                  s_d.pe.erase = 1'b1;
                  s_d.pe.addr  = s_q.ctl.pa;
                  s_d.ctl.busy = 1'b0;
               end
               OP_WORD: begin
                  s_d.pe.wr    = 1'b1;
                  s_d.pe.addr  = s_q.ctl.pa;
                  s_d.pe.data  = s_q.ctl.pd;
                  s_d.ctl.busy = 1'b0;
               end
               OP_BUF: begin
                  s_d.pe.wr   = 1'b1;
                  s_d.pe.addr = s_q.ctl.pa + WA_W'(s_q.ctl.idx);
                  s_d.pe.data = s_q.wbuf[s_q.ctl.idx];
                  if (s_q.ctl.idx == s_q.ctl.last) begin
                     s_d.ctl.busy = 1'b0;
                  end else begin
                     s_d.ctl.idx   = s_q.ctl.idx + 1'b1;
                     s_d.ctl.timer = WORD_T;
                  end
               end
               default: begin
                  s_d.ctl.busy = 1'b0;
               end
            endcase
         end
      end
      if (!s_d.ctl.busy) begin
         s_d.ctl.op = OP_NONE;
      end

      // ---------------- command interpretation
      if (do_write) begin
         s_d.bvalid  = 1'b1;
         s_d.aw_have = 1'b0;
         s_d.w_have  = 1'b0;
         case (s_q.cs)
            CS_IDLE: begin
               case (cmd)
                  OPC_READ_ARRAY: begin
                     s_d.mode[wbank] = MODE_ARRAY;
                  end
                  OPC_READ_STATUS: begin
                     s_d.mode[wbank] = MODE_STATUS;
                  end
                  OPC_READ_SIG: begin
                     s_d.mode[wbank] = MODE_SIG;
                  end
                  OPC_QUERY: begin
                     s_d.mode[wbank] = MODE_QUERY;
                  end
                  OPC_CLEAR_STAT: begin
                     if (!busy_here) begin
                        s_d.ers_err  = 1'b0;
                        s_d.prg_err  = 1'b0;  // this command, the reset pin and supply lockout clear the flags
                        s_d.prot_err = 1'b0;
                     end
                  end
                  OPC_ERASE_SETUP: begin
                     if (!s_q.ctl.busy) begin
                        s_d.cs   = CS_ERASE_SETUP;
                        s_d.base = wa;
                     end
                  end
                  OPC_PROG_SETUP, OPC_PROG_ALT: begin
                     if (!s_q.ctl.busy) begin
                        s_d.cs   = CS_PROG_SETUP;
                        s_d.base = wa;
                     end
                  end
                  OPC_BUF_PROG: begin
                     if (!busy_here && !(s_q.ers_err && s_q.prg_err)) begin
                        s_d.mode[wbank] = MODE_STATUS;
                        if (!s_q.ctl.busy) begin
                           s_d.cs   = CS_BUF_COUNT;
                           s_d.base = wa;
                        end
                     end
                  end
                  OPC_FACTORY: begin
                     if (!s_q.ctl.busy) begin
                        s_d.cs   = CS_FACT_SETUP;
                        s_d.base = wa;
                     end
                  end
                  default: begin
                  end  // suspend and undefined codes leave everything as is
               endcase
            end
            CS_ERASE_SETUP: begin
               s_d.cs          = CS_IDLE;
               s_d.mode[wbank] = MODE_STATUS;
               if (cmd != OPC_CONFIRM) begin
                  s_d.ers_err = 1'b1;
                  s_d.prg_err = 1'b1;
               end else if (block_protect[wblk]) begin
                  s_d.prot_err = 1'b1;
                  s_d.ers_err  = 1'b1;
               end else begin
                  s_d.ctl.busy  = 1'b1;
                  s_d.ctl.op    = OP_ERASE;
                  s_d.ctl.timer = ERASE_T;
                  s_d.ctl.pa    = {wblk, {(WA_W-BLK_W){1'b0}}};
               end
            end
            CS_PROG_SETUP: begin
               s_d.cs          = CS_IDLE;
               s_d.mode[wbank] = MODE_STATUS;
               if (block_protect[wblk]) begin
                  s_d.prot_err = 1'b1;
                  s_d.prg_err  = 1'b1;
               end else begin
                  s_d.ctl.busy  = 1'b1;
                  s_d.ctl.op    = OP_WORD;
                  s_d.ctl.timer = WORD_T;
                  s_d.ctl.pa    = wa;
                  s_d.ctl.pd    = s_q.w_data;
               end
            end
            CS_BUF_COUNT: begin
               if (wblk != base_blk || s_q.w_data > 16'(BUF_LAST)) begin
                  s_d.prg_err = 1'b1;
                  s_d.cs      = CS_IDLE;
               end else begin
                  s_d.nwords = s_q.w_data[CNT_W-1:0];
                  s_d.loaded = '0;
                  s_d.cs     = CS_BUF_LOAD;
               end
            end
            CS_BUF_LOAD: begin
               if (wblk != base_blk || wa < eff_start || offset > WA_W'(s_q.nwords)) begin
                  s_d.prg_err = 1'b1;
                  s_d.cs      = CS_IDLE;
               end else begin
                  s_d.start = eff_start;
                  s_d.wbuf[offset[CNT_W-1:0]] = s_q.w_data;
                  s_d.loaded = s_q.loaded + 1'b1;
                  if (s_q.loaded == {1'b0, s_q.nwords}) begin
                     s_d.cs = CS_BUF_CONFIRM;
                  end
               end
            end
            CS_BUF_CONFIRM: begin
               s_d.cs = CS_IDLE;
               if (cmd != OPC_CONFIRM || wblk != base_blk) begin
                  s_d.prg_err = 1'b1;
               end else if (block_protect[wblk]) begin
                  s_d.prot_err = 1'b1;
                  s_d.prg_err  = 1'b1;
               end else begin
                  s_d.ctl.busy  = 1'b1;
                  s_d.ctl.op    = OP_BUF;
                  s_d.ctl.timer = WORD_T;
                  s_d.ctl.idx   = '0;
                  s_d.ctl.last  = s_q.nwords;
                  s_d.ctl.pa    = s_q.start;
               end
            end
            CS_FACT_SETUP: begin
               s_d.mode[wbank] = MODE_STATUS;
               s_d.cs          = CS_IDLE;
               if (cmd != OPC_CONFIRM) begin
                  s_d.prg_err = 1'b1;
               end else if (block_protect[wblk] || wa[CNT_W-1:0] != '0) begin
                  s_d.prot_err = block_protect[wblk];
                  s_d.prg_err  = 1'b1;
               end else begin
                  s_d.start  = wa;
                  s_d.base   = wa;
                  s_d.loaded = '0;
                  s_d.cs     = CS_FACT_LOAD;
               end
            end
            CS_FACT_LOAD: begin
               if (wblk != start_blk) begin
                  s_d.cs = CS_IDLE;  // a write outside the block ends the session
               end else if (wa != s_q.start) begin
                  s_d.prg_err = 1'b1;
                  s_d.cs      = CS_IDLE;
               end else if (!s_q.ctl.busy) begin
                  s_d.wbuf[s_q.loaded[CNT_W-1:0]] = s_q.w_data;
                  s_d.loaded = s_q.loaded + 1'b1;
                  if (s_q.loaded[CNT_W-1:0] == BUF_LAST) begin
                     s_d.loaded    = '0;  // buffer refilled again in the same block
                     s_d.ctl.busy  = 1'b1;
                     s_d.ctl.op    = OP_BUF;
                     s_d.ctl.timer = WORD_T;
                     s_d.ctl.idx   = '0;
                     s_d.ctl.last  = BUF_LAST;
                     s_d.ctl.pa    = s_q.base;
                     s_d.base      = s_q.base + WA_W'(BUF_WORDS);
                  end
               end
            end
            default: begin
               s_d.cs = CS_IDLE;
            end
         endcase
      end

      // ---------------- axi read channels
      if (s_q.rvalid && rready) begin
         s_d.rvalid  = 1'b0;
         s_d.arready = 1'b1;
      end
      if (arvalid && s_q.arready) begin
         s_d.arready = 1'b0;
         s_d.rd_pend = 1'b1;
         s_d.raddr   = araddr[AXI_AW-1:2];
      end
      if (s_q.rd_pend) begin
         s_d.rd_pend = 1'b0;
         s_d.rvalid  = 1'b1;
         case (s_q.mode[s_q.raddr[WA_W-1 -: BANK_W]])
            MODE_STATUS: s_d.rdata = {24'h000000, status};
            MODE_SIG:    s_d.rdata = {16'h0000, SIG_CODE};
            MODE_QUERY:  s_d.rdata = {16'h0000, cfi_rdata};
            default:     s_d.rdata = {16'h0000, array_rdata};
         endcase
      end

      // ---------------- reset pin and supply lockout abort command sequences and program/erase
      if (reset_pin_low || vdd_low) begin
         s_d.cs       = CS_IDLE;
         s_d.mode     = '{default: MODE_ARRAY};
         s_d.ctl.busy = 1'b0;
         s_d.ctl.op   = OP_NONE;
         s_d.pe.wr    = 1'b0;
         s_d.pe.erase = 1'b0;
         s_d.ers_err  = 1'b0;
         s_d.prg_err  = 1'b0;
         s_d.prot_err = 1'b0;
      end

      s_d.awready = !s_d.aw_have;
      s_d.wready  = !s_d.w_have;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q         <= '0;
         s_q.mode    <= '{default: MODE_ARRAY};
         s_q.cs      <= CS_IDLE;
         s_q.ctl.op  <= OP_NONE;
         s_q.awready <= 1'b1;
         s_q.wready  <= 1'b1;
         s_q.arready <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign awready     = s_q.awready;
   assign wready      = s_q.wready;
   assign bvalid      = s_q.bvalid;
   assign bresp       = RESP_OKAY;
   assign arready     = s_q.arready;
   assign rvalid      = s_q.rvalid;
   assign rdata       = s_q.rdata;
   assign rresp       = RESP_OKAY;
   assign array_raddr = s_q.raddr;
   assign pe_req      = s_q.pe;
   assign pe_busy     = s_q.ctl.busy;

endmodule // flash_cmd_interp

`default_nettype wire

// [tb/flash_cmd_interp_props.sv]
// port assertions for the flash command interpreter
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_interp_props
   import flash_cmd_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic        reset_pin_low,
   input wire logic        vdd_low,
   input wire pe_req_s     pe_req,
   input wire logic        pe_busy
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_rd_ans; !rvalid ##1 rvalid; endsequence
   sequence s_pe_pulse; pe_req.wr || pe_req.erase; endsequence
   property p_rd_lat; arvalid && arready |=> s_rd_ans; endproperty
   property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   property p_b_hold; bvalid && !bready |=> bvalid; endproperty
   property p_okay; bvalid |-> bresp == RESP_OKAY; endproperty
   property p_abort;
      reset_pin_low || vdd_low |=> !pe_busy && !pe_req.wr && !pe_req.erase;
   endproperty
   property p_pulse; s_pe_pulse |=> !(pe_req.wr || pe_req.erase); endproperty
   property p_busy_end;
      $fell(pe_busy) |-> pe_req.wr || pe_req.erase || $past(reset_pin_low) || $past(vdd_low);
   endproperty
   property p_pe_busy; s_pe_pulse |-> $past(pe_busy) && !(pe_req.wr && pe_req.erase); endproperty
   property p_rst; disable iff (1'b0) !aresetn |=> !pe_busy && !bvalid && !rvalid; endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer latency");
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   a_okay: assert property (p_okay) else $error("write answer not okay");
   a_abort: assert property (p_abort) else $error("reset pin did not abort");
   a_pulse: assert property (p_pulse) else $error("array strobe too long");
   a_busy_end: assert property (p_busy_end) else $error("busy ended without cause");
   a_pe_busy: assert property (p_pe_busy) else $error("array strobe while idle");
   a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule // flash_cmd_interp_props
`default_nettype wire

// [tb/flash_array_model.sv]
// array and query space behind the interpreter
`timescale 1ns/10ps
`default_nettype none
module flash_array_model
   import flash_cmd_pkg::*;
(
   input  wire logic            aclk,
   input  wire logic [WA_W-1:0] array_raddr,
   input  wire pe_req_s         pe_req,
   output logic [15:0]          array_rdata,
   output logic [15:0]          cfi_rdata
);
   logic [15:0] mem [0:(1<<WA_W)-1];
   initial foreach (mem[i]) mem[i] = 16'hffff;
   always @(posedge aclk) begin
      // programming only clears bits
      if (pe_req.wr) mem[pe_req.addr] = mem[pe_req.addr] & pe_req.data;
      if (pe_req.erase) begin
         for (int i = 0; i < 4096; i++) mem[{pe_req.addr[15:12], i[11:0]}] = 16'hffff;
      end
   end
   assign array_rdata = mem[array_raddr];
   assign cfi_rdata   = {8'hc5, array_raddr[7:0]};
endmodule // flash_array_model
`default_nettype wire

// [tb/flash_cmd_interp_tb.sv]
// self-checking bench for the flash command interpreter
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_interp_tb import flash_cmd_pkg::*;;
   logic              aclk = 1'b0, aresetn = 1'b0;
   logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
   logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic              reset_pin_low = 0, vdd_low = 0;
   logic [31:0]       wdata = '0, rdata;
   logic [NBLK-1:0]   block_protect = 16'h0008;
   logic              awready, wready, bvalid, arready, rvalid, pe_busy;
   logic [1:0]        bresp, rresp;
   logic [15:0]       array_rdata, cfi_rdata;
   logic [WA_W-1:0]   array_raddr;
   pe_req_s           pe_req;
   int                miscompares = 0, cmp_count = 0;
   always #25 aclk = ~aclk;
   flash_cmd_interp #(.WORD_PROG_CYCLES(40), .ERASE_CYCLES(60)) i_flash_cmd_interp (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .reset_pin_low, .vdd_low, .block_protect, .array_rdata,
      .cfi_rdata, .array_raddr, .pe_req, .pe_busy);
   flash_array_model i_flash_array_model (.aclk, .array_raddr, .pe_req, .array_rdata,
      .cfi_rdata);
   function automatic logic [17:0] ba(input int b, input int w);
      return {b[3:0], w[11:0], 2'b00};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [17:0] a, input logic [15:0] d);
      int n;
      @(posedge aclk);
      awaddr <= a; wdata <= {16'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
         if (bvalid && bready) break;
      end
      bready <= 0;
      if (n == 50) miscompares++;
   endtask
   // single reads only, no bursts
   task automatic rc(input logic [17:0] a, input logic [31:0] e);
      int n;
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 0;
         if (rvalid && rready) break;
      end
      rready <= 0;
      if (n == 50) miscompares++;
      chk(rdata, e);
      chk({30'h0, rresp}, 32'h0);
   endtask
   task automatic wait_idle;
      int n;
      for (n = 0; n < 300 && pe_busy !== 1'b0; n++) @(posedge aclk);
      if (n == 300) miscompares++;
   endtask
   // query kept away from bank 3, the parameter bank
   task automatic t_query;
      wr(ba(4, 0), OPC_QUERY);
      rc(ba(5, 7), 32'hc507);
      rc(ba(0, 7), 32'hffff);
      wr(ba(4, 0), OPC_READ_ARRAY);
      rc(ba(4, 7), 32'hffff);
   endtask
   task automatic t_prog;
      wr(ba(0, 2), OPC_PROG_SETUP);
      wr(ba(0, 2), 16'h1234);
      rc(ba(1, 0), 32'h0);
      wr(ba(4, 0), OPC_PROG_SETUP);
      wr(ba(4, 0), 16'h5555);
      wr(ba(0, 0), OPC_QUERY);
      rc(ba(0, 3), 32'hc503);
      wait_idle;
      wr(ba(0, 0), OPC_READ_ARRAY);
      rc(ba(0, 2), 32'h1234);
      rc(ba(4, 0), 32'hffff);
   endtask
   task automatic t_erase;
      wr(ba(0, 0), OPC_ERASE_SETUP);
      wr(ba(0, 5), OPC_CONFIRM);
      rc(ba(2, 0), 32'h0);
      wait_idle;
      rc(ba(0, 0), 32'h80);
      wr(ba(0, 0), OPC_READ_ARRAY);
      rc(ba(0, 2), 32'hffff);
   endtask
   task automatic t_err;
      wr(ba(1, 0), OPC_ERASE_SETUP);
      wr(ba(1, 0), 16'h0000);
      wr(ba(1, 0), OPC_READ_STATUS);
      rc(ba(1, 0), 32'hb0);
      wr(ba(1, 0), OPC_BUF_PROG);
      wr(ba(1, 0), 16'h0000);
      wr(ba(1, 1), 16'h0042);
      wr(ba(1, 0), OPC_CONFIRM);
      wr(ba(1, 0), OPC_READ_STATUS);
      rc(ba(1, 0), 32'hb0);
      wr(ba(1, 0), OPC_CLEAR_STAT);
      rc(ba(1, 0), 32'h80);
      wr(ba(1, 0), OPC_READ_ARRAY);
      rc(ba(1, 1), 32'hffff);
      wr(ba(3, 0), OPC_ERASE_SETUP);
      wr(ba(3, 0), OPC_CONFIRM);
      wr(ba(3, 0), OPC_READ_STATUS);
      rc(ba(3, 0), 32'ha2);
      wr(ba(3, 0), OPC_CLEAR_STAT);
      wr(ba(3, 0), OPC_READ_ARRAY);
   endtask
   task automatic t_buf;
      wr(ba(2, 0), OPC_BUF_PROG);
      rc(ba(2, 9), 32'h80);
      wr(ba(2, 0), 16'h0001);
      wr(ba(2, 4), 16'haaaa);
      wr(ba(2, 5), 16'hbbbb);
      wr(ba(2, 0), OPC_CONFIRM);
      wait_idle;
      wr(ba(2, 0), OPC_READ_ARRAY);
      rc(ba(2, 4), 32'haaaa);
      rc(ba(2, 5), 32'hbbbb);
      rc(ba(2, 6), 32'hffff);
      // one load too many where the confirm belongs
      wr(ba(2, 0), OPC_BUF_PROG);
      wr(ba(2, 0), 16'h0000);
      wr(ba(2, 8), 16'hcccc);
      wr(ba(2, 9), 16'hdddd);
      wr(ba(2, 0), OPC_CONFIRM);
      wr(ba(2, 0), OPC_READ_STATUS);
      rc(ba(2, 0), 32'h90);
      wr(ba(2, 0), OPC_CLEAR_STAT);
      wr(ba(2, 0), OPC_READ_ARRAY);
      rc(ba(2, 8), 32'hffff);
   endtask
   task automatic t_fact;
      wr(ba(6, 0), OPC_FACTORY);
      wr(ba(6, 0), OPC_CONFIRM);
      wr(ba(6, 0), 16'h1111);
      wr(ba(7, 0), 16'h00ff);
      wr(ba(6, 0), OPC_READ_ARRAY);
      rc(ba(6, 0), 32'hffff);
      wr(ba(6, 0), OPC_FACTORY);
      wr(ba(6, 0), OPC_CONFIRM);
      wr(ba(6, 1), 16'h2222);
      rc(ba(6, 0), 32'h90);
      wr(ba(3, 0), OPC_FACTORY);
      wr(ba(3, 0), OPC_CONFIRM);
      rc(ba(3, 0), 32'h92);
      wr(ba(3, 0), OPC_CLEAR_STAT);
      wr(ba(3, 0), OPC_READ_ARRAY);
      wr(ba(6, 0), OPC_READ_ARRAY);
   endtask
   task automatic t_rst;
      for (int i = 0; i < 2; i++) begin
         wr(ba(4, 1), i ? OPC_ERASE_SETUP : OPC_PROG_SETUP);
         wr(ba(4, 1), i ? 16'h00d0 : 16'h0000);
         chk({31'h0, pe_busy}, 32'h1);
         @(posedge aclk);
         if (i == 0) reset_pin_low <= 1;
         else vdd_low <= 1;
         @(posedge aclk);
         reset_pin_low <= 0;
         vdd_low <= 0;
         @(posedge aclk);
         chk({31'h0, pe_busy}, 32'h0);
         rc(ba(4, 1), 32'hffff);
      end
   endtask
   task automatic end_of_test;
      if (miscompares == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      t_query;
      t_prog;
      t_erase;
      t_err;
      t_buf;
      t_fact;
      t_rst;
      end_of_test;
   end
   initial begin
      repeat (8000) @(posedge aclk);
      miscompares++;
      end_of_test;
   end
endmodule // flash_cmd_interp_tb
bind flash_cmd_interp flash_cmd_interp_props i_flash_cmd_interp_props (.aclk, .aresetn,
   .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
   .reset_pin_low, .vdd_low, .pe_req, .pe_busy);
`default_nettype wire
